// [rtl/serial_loader_pkg.sv]
// constants for the serial program loader
`default_nettype none
package serial_loader_pkg;
    // clock and timing
    localparam int CLK_MHZ = 25;
    localparam int EEPROM_BYTE_WRITE_DELAY_US = 4000;
    localparam int EEPROM_WRITE_CYCLES = EEPROM_BYTE_WRITE_DELAY_US * CLK_MHZ;
    localparam int POR_SAMPLE_CYCLES = 2;
    // instruction codes, bytes 1 and 2
    localparam logic [7:0] OPC_ENABLE_ERASE = 8'hAC;
    localparam logic [7:0] OPC_ENABLE_ECHO = 8'h53;
    localparam logic [7:0] OPC_READ_EE = 8'hA0;
    localparam logic [7:0] OPC_WRITE_EE = 8'hC0;
    localparam logic [7:0] OPC_WRITE_PAGE = 8'h4C;
    localparam logic [7:0] OPC_READ_LOCK = 8'h58;
    localparam logic [7:0] OPC_READ_FUSE = 8'h50;
    localparam logic [7:0] OPC_READ_SIG = 8'h30;
    localparam logic [3:0] OPC_READ_FLASH_HI = 4'h2;
    localparam logic [3:0] OPC_LOAD_PAGE_HI = 4'h4;
    localparam logic [2:0] OPC_ERASE_B2 = 3'b100;
    localparam logic [4:0] OPC_LOCK_B2 = 5'h1F;
    localparam logic [3:0] OPC_FUSE_B2 = 4'hB;
    // fuse and lock state, zero means programmed
    localparam logic [2:0] FUSE_RESET = 3'h7;
    localparam logic [1:0] LOCK_RESET = 2'h3;
    localparam logic [7:0] SIG_BYTE0 = 8'h11; // arbitrary value
    localparam logic [7:0] SIG_BYTE1 = 8'h22; // arbitrary value
    localparam logic [7:0] SIG_BYTE2 = 8'h33; // arbitrary value
    // register map, byte addresses
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_POLL = 4'h4;
    localparam logic [3:0] REG_FUSE_LOCK = 4'h8;
    localparam logic [7:0] ERASE_POLL_RESET = 8'hFF;
    localparam logic [7:0] WRITE_POLL_RESET = 8'h7F;
    // memory port operations
    typedef enum logic [2:0] {
        OP_READ_FLASH = 3'h0,
        OP_LOAD_PAGE = 3'h1,
        OP_WRITE_PAGE = 3'h2,
        OP_READ_EE = 3'h3,
        OP_WRITE_EE = 3'h4,
        OP_CHIP_ERASE = 3'h5
    } mem_op_t;
    // eeprom write progress
    typedef enum logic [2:0] {
        EE_IDLE = 3'b001,
        EE_ERASE = 3'b010,
        EE_WRITE = 3'b100
    } ee_phase_t;
endpackage : serial_loader_pkg
`default_nettype wire

// [rtl/serial_program_loader.sv]
// serial in-system programming port with avalon status slave
// Behaviour
// - sample input on rise, shift output on fall
// - power-on select pin level caught once
// - echo byte two during byte three
// - page buffer loaded by low, committed high
// - eeprom reads of the address being written return poll values while busy
// - no polling indication for flash writes
// - data output always driven in session
// - programming enable decoded, only in session
// - chip erase clears flash, eeprom, locks
// - flash read returns selected byte
// - page load and page write formats
// - eeprom read and write formats
// - lock and fuse read and write
// - refuse commands until enable executed
`default_nettype none
module serial_program_loader #(
    parameter int EE_WRITE_CYCLES = serial_loader_pkg::EEPROM_WRITE_CYCLES
) (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic RST_IN,
    // serial programming pins
    input wire logic SERIAL_PROG_CLOCK_IN,
    input wire logic SERIAL_PROG_DATA_IN,
    input wire logic TARGET_RESET_N_IN,
    input wire logic POWER_ON_PROGRAM_SELECT_PIN_N_IN,
    output logic SERIAL_PROG_DATA_OUT,
    // memory array port
    output logic MEM_REQ_OUT,
    output logic [2:0] MEM_OP_OUT,
    output logic [15:0] MEM_ADDR_OUT,
    output logic [7:0] MEM_WDATA_OUT,
    output logic MEM_HIGH_OUT,
    input wire logic [7:0] MEM_RDATA_IN,
    // avalon-mm slave
    input wire logic [3:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [31:0] AVS_WRITEDATA_IN,
    input wire logic [3:0] AVS_BYTEENABLE_IN,
    output logic [31:0] AVS_READDATA_OUT,
    output logic AVS_WAITREQUEST_OUT
);
    localparam logic [16:0] EE_TOTAL = 17'(EE_WRITE_CYCLES);
    localparam logic [16:0] EE_HALF = 17'(EE_WRITE_CYCLES / 2);

    logic sck_s1, sck_s2, sck_s3, pdi_s1, pdi_s2, rstp_s1, rstp_s2, pen_s1, pen_s2;
    logic [1:0] por_cnt;
    logic por_done, pen_mode, session, rise, fall;
    logic [4:0] bit_cnt;
    logic [31:0] shreg, next_shift;
    logic [7:0] out_byte;
    logic prog_en, rd_pending;
    logic [2:0] fuse;
    logic [1:0] lock;
    logic [7:0] erase_poll, write_poll;
    logic [11:0] ee_addr;
    logic [16:0] ee_cnt;
    serial_loader_pkg::ee_phase_t ee_phase;
    logic ack;
    logic [7:0] c1, c2, c3, b1, b2, b3, b4;
    logic at_read, at_exec, is_pe, is_erase, is_lock_w, is_fuse_w;
    logic is_load, is_wpage, is_wee, is_ree, is_rflash, ee_hit;

    // input synchronisers
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            sck_s1 <= 1'b0;
            sck_s2 <= 1'b0;
            sck_s3 <= 1'b0;
            pdi_s1 <= 1'b0;
            pdi_s2 <= 1'b0;
            rstp_s1 <= 1'b1;
            rstp_s2 <= 1'b1;
            pen_s1 <= 1'b1;
            pen_s2 <= 1'b1;
        end else begin
            sck_s1 <= SERIAL_PROG_CLOCK_IN;
            sck_s2 <= sck_s1;
            sck_s3 <= sck_s2;
            pdi_s1 <= SERIAL_PROG_DATA_IN;
            pdi_s2 <= pdi_s1;
            rstp_s1 <= TARGET_RESET_N_IN;
            rstp_s2 <= rstp_s1;
            pen_s1 <= POWER_ON_PROGRAM_SELECT_PIN_N_IN;
            pen_s2 <= pen_s1;
        end
    end

    assign rise = sck_s2 & ~sck_s3;
    assign fall = ~sck_s2 & sck_s3;

    // power-on select pin caught once after release
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            por_cnt <= 2'h0;
            por_done <= 1'b0;
            pen_mode <= 1'b0;
        end else if (!por_done) begin
            por_cnt <= por_cnt + 2'h1;
            if (por_cnt == 2'(serial_loader_pkg::POR_SAMPLE_CYCLES)) begin
                por_done <= 1'b1;
                pen_mode <= ~pen_s2;
            end
        end
    end

    assign session = por_done & (pen_mode | ~rstp_s2);

    // instruction decode
    assign next_shift = {shreg[30:0], pdi_s2};
    assign c1 = next_shift[23:16];
    assign c2 = next_shift[15:8];
    assign c3 = next_shift[7:0];
    assign b1 = next_shift[31:24];
    assign b2 = next_shift[23:16];
    assign b3 = next_shift[15:8];
    assign b4 = next_shift[7:0];
    assign at_read = session & rise & (bit_cnt == 5'h17) & prog_en;
    assign at_exec = session & rise & (bit_cnt == 5'h1F);
    assign is_pe = (b1 == serial_loader_pkg::OPC_ENABLE_ERASE)
        & (b2 == serial_loader_pkg::OPC_ENABLE_ECHO);
    assign is_erase = (b1 == serial_loader_pkg::OPC_ENABLE_ERASE)
        & (b2[7:5] == serial_loader_pkg::OPC_ERASE_B2);
    assign is_lock_w = (b1 == serial_loader_pkg::OPC_ENABLE_ERASE)
        & (b2[7:3] == serial_loader_pkg::OPC_LOCK_B2) & b2[0];
    assign is_fuse_w = (b1 == serial_loader_pkg::OPC_ENABLE_ERASE)
        & (b2[7:4] == serial_loader_pkg::OPC_FUSE_B2);
    assign is_load = (b1[7:4] == serial_loader_pkg::OPC_LOAD_PAGE_HI)
        & (b1[2:0] == 3'h0);
    assign is_wpage = (b1 == serial_loader_pkg::OPC_WRITE_PAGE);
    assign is_wee = (b1 == serial_loader_pkg::OPC_WRITE_EE);
    assign is_ree = (c1 == serial_loader_pkg::OPC_READ_EE);
    assign is_rflash = (c1[7:4] == serial_loader_pkg::OPC_READ_FLASH_HI)
        & (c1[2:0] == 3'h0);
    assign ee_hit = (ee_phase != serial_loader_pkg::EE_IDLE)
        & ({c2[3:0], c3} == ee_addr);

    // bit counter and shift register
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            bit_cnt <= 5'h0;
            shreg <= 32'h0;
        end else if (!session) begin
            bit_cnt <= 5'h0;
        end else if (rise) begin
            bit_cnt <= bit_cnt + 5'h1;
            shreg <= next_shift;
        end
    end

    // programming enable flag
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            prog_en <= 1'b0;
        end else if (!session) begin
            prog_en <= 1'b0;
        end else if (at_exec && is_pe) begin
            prog_en <= 1'b1;
        end
    end

    // read-back byte
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            out_byte <= 8'h0;
            rd_pending <= 1'b0;
        end else begin
            rd_pending <= 1'b0;
            if (rd_pending) begin
                out_byte <= MEM_RDATA_IN;
            end else if (session && rise && bit_cnt == 5'h0F) begin
                out_byte <= c3;
            end else if (at_read) begin
                if (is_ree && ee_hit) begin
                    out_byte <= (ee_phase == serial_loader_pkg::EE_ERASE) ?
                        erase_poll : write_poll;
                end else if (is_ree || is_rflash) begin
                    rd_pending <= 1'b1;
                end else if (c1 == serial_loader_pkg::OPC_READ_LOCK) begin
                    out_byte <= {5'h1F, lock, 1'b1};
                end else if (c1 == serial_loader_pkg::OPC_READ_FUSE) begin
                    out_byte <= {3'h7, 1'b1, fuse[2], 1'b1, fuse[1:0]};
                end else if (c1 == serial_loader_pkg::OPC_READ_SIG) begin
                    unique case (c3[1:0])
                        2'h0: out_byte <= serial_loader_pkg::SIG_BYTE0;
                        2'h1: out_byte <= serial_loader_pkg::SIG_BYTE1;
                        default: out_byte <= serial_loader_pkg::SIG_BYTE2;
                    endcase
                end else begin
                    out_byte <= 8'h0;
                end
            end else if (session && rise && bit_cnt == 5'h17) begin
                out_byte <= 8'h0;
            end else if (at_exec) begin
                out_byte <= 8'h0;
            end
        end
    end

    // serial output, always driven
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            SERIAL_PROG_DATA_OUT <= 1'b0;
        end else if (fall) begin
            SERIAL_PROG_DATA_OUT <= out_byte[3'h7 - bit_cnt[2:0]];
        end
    end

    // memory port requests
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            MEM_REQ_OUT <= 1'b0;
            MEM_OP_OUT <= serial_loader_pkg::OP_READ_FLASH;
            MEM_ADDR_OUT <= 16'h0;
            MEM_WDATA_OUT <= 8'h0;
            MEM_HIGH_OUT <= 1'b0;
        end else begin
            MEM_REQ_OUT <= 1'b0;
            if (at_read && is_rflash) begin
                MEM_REQ_OUT <= 1'b1;
                MEM_OP_OUT <= serial_loader_pkg::OP_READ_FLASH;
                MEM_ADDR_OUT <= {c2, c3};
                MEM_HIGH_OUT <= c1[3];
            end else if (at_read && is_ree && !ee_hit) begin
                MEM_REQ_OUT <= 1'b1;
                MEM_OP_OUT <= serial_loader_pkg::OP_READ_EE;
                MEM_ADDR_OUT <= {4'h0, c2[3:0], c3};
            end else if (at_exec && prog_en) begin
                MEM_WDATA_OUT <= b4;
                MEM_HIGH_OUT <= b1[3];
                if (is_load) begin
                    MEM_REQ_OUT <= 1'b1;
                    MEM_OP_OUT <= serial_loader_pkg::OP_LOAD_PAGE;
                    MEM_ADDR_OUT <= {9'h0, b3[6:0]};
                end else if (is_wpage) begin
                    MEM_REQ_OUT <= 1'b1;
                    MEM_OP_OUT <= serial_loader_pkg::OP_WRITE_PAGE;
                    MEM_ADDR_OUT <= {b2, b3[7], 7'h0};
                end else if (is_wee) begin
                    MEM_REQ_OUT <= 1'b1;
                    MEM_OP_OUT <= serial_loader_pkg::OP_WRITE_EE;
                    MEM_ADDR_OUT <= {4'h0, b2[3:0], b3};
                end else if (is_erase) begin
                    MEM_REQ_OUT <= 1'b1;
                    MEM_OP_OUT <= serial_loader_pkg::OP_CHIP_ERASE;
                end
            end
        end
    end

    // eeprom write progress for polling
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ee_phase <= serial_loader_pkg::EE_IDLE;
            ee_cnt <= 17'h0;
            ee_addr <= 12'h0;
        end else if (at_exec && prog_en && is_wee) begin
            ee_phase <= serial_loader_pkg::EE_ERASE;
            ee_cnt <= 17'h0;
            ee_addr <= {b2[3:0], b3};
        end else begin
            unique case (ee_phase)
                serial_loader_pkg::EE_IDLE: ee_cnt <= 17'h0;
                serial_loader_pkg::EE_ERASE: begin
                    ee_cnt <= ee_cnt + 17'h1;
                    if (ee_cnt >= EE_HALF) begin
                        ee_phase <= serial_loader_pkg::EE_WRITE;
                    end
                end
                serial_loader_pkg::EE_WRITE: begin
                    ee_cnt <= ee_cnt + 17'h1;
                    if (ee_cnt >= EE_TOTAL) begin
                        ee_phase <= serial_loader_pkg::EE_IDLE;
                    end
                end
                default: ee_phase <= serial_loader_pkg::EE_IDLE;
            endcase
        end
    end

    // lock and fuse bits
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            lock <= serial_loader_pkg::LOCK_RESET;
            fuse <= serial_loader_pkg::FUSE_RESET;
        end else if (at_exec && prog_en) begin
            if (is_erase) begin
                lock <= serial_loader_pkg::LOCK_RESET;
            end else if (is_lock_w) begin
                lock <= lock & b2[2:1];
            end else if (is_fuse_w) begin
                fuse <= {b2[3], b2[1:0]};
            end
        end
    end

    // avalon slave, one wait cycle per access
    assign AVS_WAITREQUEST_OUT = (AVS_READ_IN | AVS_WRITE_IN) & ~ack;

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ack <= 1'b0;
            AVS_READDATA_OUT <= 32'h0;
        end else begin
            ack <= (AVS_READ_IN | AVS_WRITE_IN) & ~ack;
            if (AVS_READ_IN && !ack) begin
                unique case (AVS_ADDRESS_IN)
                    serial_loader_pkg::REG_STATUS: AVS_READDATA_OUT <= {28'h0,
                        ee_phase != serial_loader_pkg::EE_IDLE, pen_mode, prog_en, session};
                    serial_loader_pkg::REG_POLL:
                        AVS_READDATA_OUT <= {16'h0, write_poll, erase_poll};
                    serial_loader_pkg::REG_FUSE_LOCK:
                        AVS_READDATA_OUT <= {22'h0, lock, 5'h0, fuse};
                    default: AVS_READDATA_OUT <= 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            erase_poll <= serial_loader_pkg::ERASE_POLL_RESET;
            write_poll <= serial_loader_pkg::WRITE_POLL_RESET;
        end else if (AVS_WRITE_IN && ack && AVS_ADDRESS_IN == serial_loader_pkg::REG_POLL) begin
            if (AVS_BYTEENABLE_IN[0]) begin
                erase_poll <= AVS_WRITEDATA_IN[7:0];
            end
            if (AVS_BYTEENABLE_IN[1]) begin
                write_poll <= AVS_WRITEDATA_IN[15:8];
            end
        end
    end

    // checks
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);

    property p_rise_count;
        session && rise |=> bit_cnt == $past(bit_cnt) + 5'h1;
    endproperty
    a_rise_count: assert property (p_rise_count) else $error("bit count missed rise");

    property p_out_on_fall;
        !fall |=> $stable(SERIAL_PROG_DATA_OUT);
    endproperty
    a_out_on_fall: assert property (p_out_on_fall) else $error("output moved off fall");

    property p_echo;
        session && rise && bit_cnt == 5'h0F |=> out_byte == $past(c3);
    endproperty
    a_echo: assert property (p_echo) else $error("echo byte wrong");

    property p_enable;
        at_exec && is_pe |=> prog_en;
    endproperty
    a_enable: assert property (p_enable) else $error("enable not taken");

    property p_refuse;
        MEM_REQ_OUT |-> $past(prog_en);
    endproperty
    a_refuse: assert property (p_refuse) else $error("request before enable");

    property p_resync;
        !session |=> bit_cnt == 5'h0 && !prog_en;
    endproperty
    a_resync: assert property (p_resync) else $error("counter kept out of session");

    property p_erase_lock;
        at_exec && prog_en && is_erase |=> lock == serial_loader_pkg::LOCK_RESET
            && MEM_OP_OUT == serial_loader_pkg::OP_CHIP_ERASE;
    endproperty
    a_erase_lock: assert property (p_erase_lock) else $error("erase incomplete");

    property p_page_write;
        at_exec && prog_en && is_wpage |=> MEM_REQ_OUT
            && MEM_ADDR_OUT[15:7] == {$past(b2), $past(b3[7])};
    endproperty
    a_page_write: assert property (p_page_write) else $error("page address wrong");

    property p_poll_erase;
        at_read && is_ree && ee_hit && ee_phase == serial_loader_pkg::EE_ERASE
            |=> out_byte == erase_poll;
    endproperty
    a_poll_erase: assert property (p_poll_erase) else $error("poll value wrong");

    property p_ee_start;
        at_exec && prog_en && is_wee |=> ee_phase == serial_loader_pkg::EE_ERASE ##1
            ee_phase != serial_loader_pkg::EE_IDLE;
    endproperty
    a_ee_start: assert property (p_ee_start) else $error("eeprom write not started");

    c_enable: cover property (at_exec && is_pe);
    c_ee_write: cover property (at_exec && prog_en && is_wee);
    c_flash_read: cover property (at_read && is_rflash ##1 rd_pending);
    c_poll_hit: cover property (at_read && is_ree && ee_hit);
endmodule : serial_program_loader
`default_nettype wire

// [bench/prog.sv]
// serial programmer model driving the loader's programming pins
`default_nettype none
module prog #(
    parameter int HALF = 4,
    parameter int WAKE = 40
) (
    // clock and read-back
    input wire logic clk,
    input wire logic sdo,
    // programming pins
    output logic sck,
    output logic sdi,
    output logic trst_n,
    output logic pen_n
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        sck = 1'b0;
        sdi = 1'b0;
        trst_n = 1'b0;
        pen_n = 1'b1;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_clk
    task automatic set_pins(input logic r, input logic p);
        trst_n <= r;
        pen_n <= p;
        wait_clk(1);
    endtask : set_pins
    // one bit each way, read-back taken late in the high phase
    task automatic bit_io(input logic b, output logic q);
        sdi <= b;
        wait_clk(HALF);
        sck <= 1'b1;
        wait_clk(HALF);
        q = sdo;
        sck <= 1'b0;
    endtask : bit_io
    task automatic xfer(input logic [31:0] ins, output logic [31:0] got);
        for (int i = 31; i >= 0; i--) begin
            bit_io(ins[i], got[i]);
        end
    endtask : xfer
    task automatic slip();
        logic q;
        bit_io(1'b0, q);
    endtask : slip
    task automatic pulse_reset();
        wait_clk(2 * WAKE);
        trst_n <= 1'b1;
        wait_clk(3);
        trst_n <= 1'b0;
        wait_clk(8);
    endtask : pulse_reset
    task automatic enable(output logic ok);
        logic [31:0] g;
        ok = 1'b0;
        wait_clk(WAKE);
        for (int n = 0; n < 32 && ok !== 1'b1; n++) begin
            xfer(32'hAC53_0000, g);
            ok = (g[15:8] === 8'h53);
            if (ok !== 1'b1) begin
                slip();
            end
        end
    endtask : enable
endmodule : prog
`default_nettype wire

// [bench/testbench.sv]
// self-checking bench for the serial program loader
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [3:0] ST = serial_loader_pkg::REG_STATUS;
    localparam logic [3:0] PL = serial_loader_pkg::REG_POLL;
    localparam logic [3:0] FL = serial_loader_pkg::REG_FUSE_LOCK;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sck, sdi, trst_n, pen_n, sdo, mreq, mhi, lhi;
    logic [2:0] mop, lop;
    logic [15:0] maddr, laddr;
    logic [7:0] mwd, lwd;
    logic [7:0] mrd;
    logic [3:0] av_a = 4'h0;
    logic [3:0] av_be = 4'hF;
    logic av_r = 1'b0;
    logic av_w = 1'b0;
    logic av_wt;
    logic [31:0] av_wd = 32'h0;
    logic [31:0] av_rd;
    int req_n = 0;
    int bad_count = 0;
    int n_checks = 0;
    always #20 clk = ~clk;
    // memory array stand-in, read data valid in the same cycle as the request
    assign mrd = maddr[7:0] ^ {mhi, 7'h5A};
    always @(posedge clk) begin
        if (mreq === 1'b1) begin
            req_n <= req_n + 1;
            lop <= mop;
            laddr <= maddr;
            lwd <= mwd;
            lhi <= mhi;
        end
    end
    serial_program_loader #(.EE_WRITE_CYCLES(600)) serial_program_loader_inst (
        .CLK_IN(clk), .RST_IN(rst), .SERIAL_PROG_CLOCK_IN(sck), .SERIAL_PROG_DATA_IN(sdi),
        .TARGET_RESET_N_IN(trst_n), .POWER_ON_PROGRAM_SELECT_PIN_N_IN(pen_n),
        .SERIAL_PROG_DATA_OUT(sdo), .MEM_REQ_OUT(mreq), .MEM_OP_OUT(mop),
        .MEM_ADDR_OUT(maddr), .MEM_WDATA_OUT(mwd), .MEM_HIGH_OUT(mhi), .MEM_RDATA_IN(mrd),
        .AVS_ADDRESS_IN(av_a), .AVS_READ_IN(av_r), .AVS_WRITE_IN(av_w),
        .AVS_WRITEDATA_IN(av_wd), .AVS_BYTEENABLE_IN(av_be), .AVS_READDATA_OUT(av_rd),
        .AVS_WAITREQUEST_OUT(av_wt));
    prog prog_inst (.clk(clk), .sdo(sdo), .sck(sck), .sdi(sdi), .trst_n(trst_n),
        .pen_n(pen_n));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int t;
        t = 0;
        @(posedge clk);
        av_a <= a;
        av_wd <= d;
        av_r <= !wr;
        av_w <= wr;
        do begin
            @(posedge clk);
            t++;
        end while (av_wt !== 1'b0 && t < 50);
        q = av_rd;
        av_r <= 1'b0;
        av_w <= 1'b0;
        if (t >= 50) begin
            bad_count++;
            $display("Error avalon_wait expected 0 seen 1");
            tally_and_finish();
        end
    endtask : av
    task automatic cmd(input logic [31:0] ins, input int nreq, output logic [31:0] g);
        int n0;
        n0 = req_n;
        prog_inst.xfer(ins, g);
        prog_inst.wait_clk(4);
        if (nreq >= 0) begin
            check("mem_req_count", nreq, req_n - n0);
        end
    endtask : cmd
    task automatic check_mem(input logic [2:0] op, input logic [15:0] a);
        check("mem_op_addr", {13'h0, op, a}, {13'h0, lop, laddr});
    endtask : check_mem
    task automatic t_regs();
        logic [31:0] q;
        av(1'b0, PL, 32'h0, q);
        check("poll_reset", 32'h0000_7FFF, q);
        av(1'b1, FL, 32'h0, q);
        av(1'b0, FL, 32'h0, q);
        check("fuse_lock_reset", 32'h0000_0307, q);
        av(1'b0, 4'hC, 32'h0, q);
        check("unmapped", 32'h0, q);
        av(1'b0, ST, 32'h0, q);
        check("status_idle", 32'h1, q);
        $display("test regs done");
    endtask : t_regs
    task automatic t_refuse();
        logic [31:0] g;
        cmd(32'h2812_3400, 0, g);
        check("read_refused", 32'h0, {24'h0, g[7:0]});
        cmd(32'hAC80_0000, 0, g);
        $display("test refuse done");
    endtask : t_refuse
    task automatic t_enable();
        logic [31:0] q;
        logic ok;
        prog_inst.enable(ok);
        check("enable_echo", 32'h1, {31'h0, ok});
        av(1'b0, ST, 32'h0, q);
        check("status_enabled", 32'h3, q);
        $display("test enable done");
    endtask : t_enable
    task automatic t_flash();
        logic [31:0] g;
        for (int h = 0; h < 2; h++) begin
            cmd({4'h2, h[0], 3'h0, 24'h12_3400}, 1, g);
            check_mem(serial_loader_pkg::OP_READ_FLASH, 16'h1234);
            check("flash_rd", {7'h0, h[0], 8'h12, 8'h34 ^ {h[0], 7'h5A}},
                {7'h0, lhi, g[15:0]});
        end
        cmd(32'h4800_85A5, 1, g);
        check_mem(serial_loader_pkg::OP_LOAD_PAGE, 16'h0005);
        check("page_byte", 32'h1A5, {23'h0, lhi, lwd});
        cmd(32'h4C12_8000, 1, g);
        check_mem(serial_loader_pkg::OP_WRITE_PAGE, 16'h1280);
        prog_inst.wait_clk(100);
        cmd(32'h2012_8000, 1, g);
        check("flash_no_poll", 32'h80 ^ 32'h5A, {24'h0, g[7:0]});
        cmd(32'h3000_0100, 0, g);
        check("sig_byte", {24'h0, serial_loader_pkg::SIG_BYTE1}, {24'h0, g[7:0]});
        $display("test flash done");
    endtask : t_flash
    task automatic t_ee();
        logic [31:0] g;
        logic [31:0] q;
        av_be <= 4'h1;
        av(1'b1, PL, 32'h0000_C3A5, q);
        av(1'b0, PL, 32'h0, q);
        check("poll_be", 32'h0000_7FA5, q);
        cmd(32'hC00A_BC3C, 1, g);
        check_mem(serial_loader_pkg::OP_WRITE_EE, 16'h0ABC);
        check("ee_wdata", 32'h3C, {24'h0, lwd});
        av(1'b0, ST, 32'h0, q);
        check("status_busy", 32'hB, q);
        cmd(32'hA00A_BC00, -1, g);
        check("ee_poll_erase", 32'hA5, {24'h0, g[7:0]});
        cmd(32'hA00A_BC00, -1, g);
        check("ee_poll_write", 32'h7F, {24'h0, g[7:0]});
        cmd(32'hA00A_BC00, 1, g);
        check_mem(serial_loader_pkg::OP_READ_EE, 16'h0ABC);
        check("ee_data", 32'hBC ^ 32'h5A, {24'h0, g[7:0]});
        cmd(32'hC00A_BC7F, 1, g);
        prog_inst.wait_clk(610);
        cmd(32'hA00A_BC00, 1, g);
        check("ee_after_wait", 32'hBC ^ 32'h5A, {24'h0, g[7:0]});
        $display("test eeprom done");
    endtask : t_ee
    task automatic t_lockfuse();
        logic [31:0] g;
        logic [31:0] q;
        logic ok;
        cmd(32'hACF9_0000, 0, g);
        cmd(32'h5800_0000, 0, g);
        check("lock_prog", 32'h0, {30'h0, g[2:1]});
        cmd(32'hACB6_0000, 0, g);
        cmd(32'h5000_0000, 0, g);
        check("fuse_read", 32'hA, {28'h0, g[5], g[3], g[1:0]});
        av(1'b0, FL, 32'h0, q);
        check("fuse_lock_reg", 32'h002, q);
        cmd(32'hAC80_0000, 1, g);
        check("erase_op", {29'h0, serial_loader_pkg::OP_CHIP_ERASE}, {29'h0, lop});
        prog_inst.pulse_reset();
        prog_inst.enable(ok);
        cmd(32'h5800_0000, 0, g);
        check("lock_erased", 32'h3, {30'h0, g[2:1]});
        $display("test lock fuse done");
    endtask : t_lockfuse
    task automatic t_resync();
        logic [31:0] g;
        logic ok;
        prog_inst.slip();
        prog_inst.enable(ok);
        check("resync_retry", 32'h1, {31'h0, ok});
        prog_inst.slip();
        prog_inst.pulse_reset();
        prog_inst.xfer(32'hAC53_0000, g);
        check("resync_echo", 32'h53, {24'h0, g[15:8]});
        $display("test resync done");
    endtask : t_resync
    task automatic t_pen();
        logic [31:0] q;
        logic ok;
        prog_inst.set_pins(1'b1, 1'b0);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        prog_inst.wait_clk(6);
        prog_inst.set_pins(1'b1, 1'b1);
        av(1'b0, ST, 32'h0, q);
        check("pen_session", 32'h5, q & 32'h5);
        prog_inst.enable(ok);
        check("pen_enable", 32'h1, {31'h0, ok});
        $display("test power-on select done");
    endtask : t_pen
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        t_regs();
        t_refuse();
        t_enable();
        t_flash();
        t_ee();
        t_lockfuse();
        t_resync();
        t_pen();
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
